// *** core/rsb_pkg.sv ***
package rsb_pkg;

    // Status addresses on the serial port
    localparam logic [5:0] RSB_ADDR_PART = 6'h30;
    localparam logic [5:0] RSB_ADDR_REV = 6'h31;
    localparam logic [5:0] RSB_ADDR_OFFSET = 6'h32;
    localparam logic [5:0] RSB_ADDR_LINK = 6'h33;
    localparam logic [5:0] RSB_ADDR_SIGNAL_STRENGTH_LEVEL = 6'h34;
    localparam logic [5:0] RSB_ADDR_FSM = 6'h35;

    // Header byte layout
    localparam int RSB_HDR_READ_BIT = 7;
    localparam int RSB_HDR_BURST_BIT = 6;
    localparam int RSB_HDR_ADDR_MSB = 5;

    // Identity codes, values arbitrary
    localparam logic [7:0] RSB_PART_ID_DEF = 8'h5A;
    localparam logic [7:0] RSB_REV_ID_DEF = 8'h3C;

    // Reset and fill values
    localparam logic [7:0] RSB_RST_BYTE = 8'h00;
    localparam logic [7:0] RSB_HDR_STATUS = 8'h00;
    localparam logic [2:0] RSB_FSM_PAD = 3'h0;

    // Offset estimate step is xtal divided by two to this power
    localparam int RSB_OFFSET_STEP_LOG2 = 14;

    // Link quality window
    localparam int RSB_LQI_SYMBOLS = 64;
    localparam int RSB_LQI_QWIDTH = 7;

    // Radio control state codes
    localparam logic [4:0] RSB_ST_SLEEP = 5'h00;
    localparam logic [4:0] RSB_ST_IDLE = 5'h01;
    localparam logic [4:0] RSB_ST_CRYSTAL_OFF_STATE = 5'h02;
    localparam logic [4:0] RSB_ST_RX = 5'h0D;
    localparam logic [4:0] RSB_ST_RX_RST = 5'h0F;
    localparam logic [4:0] RSB_ST_RX_OVERRUN = 5'h11;
    localparam logic [4:0] RSB_ST_TX_STARVED = 5'h16;

    typedef struct packed {
        logic chip_select_low_n;
        logic sclk;
        logic si;
    } rsb_spi_in_t;

    typedef struct packed {
        logic [7:0] freq_offset;
        logic offset_valid;
        logic mod_is_ask;
        logic crc_done;
        logic crc_match;
        logic rx_enter;
        logic [7:0] signal_strength_level;
        logic [4:0] radio_state;
    } rsb_radio_in_t;

    typedef struct packed {
        logic sync_found;
        logic sym_valid;
        logic [RSB_LQI_QWIDTH-1:0] sym_quality;
    } rsb_sym_in_t;

    typedef enum logic [1:0] {
        RSB_PH_HEADER,
        RSB_PH_DATA,
        RSB_PH_IGNORE
    } rsb_phase_t;

    typedef struct packed {
        rsb_phase_t phase;
        logic [5:0] addr;
        logic [7:0] tx_byte;
        logic [7:0] offset_est;
        logic crc_ok;
        logic [6:0] lqi;
        logic [7:0] signal_strength_level;
        logic [4:0] radio_st;
        logic cs_q;
        logic wake;
    } rsb_bank_state_t;

endpackage

// *** core/rsb_spi_shifter.sv ***
`timescale 1ns/1ps
module rsb_spi_shifter (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Serial pins
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_si,
    output logic o_so,
    output logic o_so_oe,
    // Byte side
    input wire logic [7:0] i_tx_byte,
    output logic o_byte_done,
    output logic [7:0] o_rx_byte
);
    import rsb_pkg::*;

    typedef struct packed {
        logic sclk_q;
        logic [2:0] cnt;
        logic [7:0] rx_sh;
        logic [7:0] tx_sh;
    } rsb_shift_state_t;

    rsb_shift_state_t s_reg;
    rsb_shift_state_t s_next;
    logic rise;
    logic fall;

    // Pins are synchronous, so plain edge detect on the sampled clock
    assign rise = i_sclk && !s_reg.sclk_q;
    assign fall = !i_sclk && s_reg.sclk_q;
    assign o_byte_done = i_clk_en && !i_cs_n && rise && (s_reg.cnt == 3'h7);
    assign o_rx_byte = {s_reg.rx_sh[6:0], i_si};
    assign o_so = s_reg.tx_sh[7];
    assign o_so_oe = !i_cs_n;

    always_comb
    begin
        s_next = s_reg;
        s_next.sclk_q = i_sclk;
        if (i_cs_n)
        begin
            s_next.cnt = 3'h0;
            s_next.tx_sh = i_tx_byte;
        end
        else
        begin
            if (rise)
            begin
                s_next.rx_sh = {s_reg.rx_sh[6:0], i_si};
                s_next.cnt = s_reg.cnt + 3'h1;
            end
            // Next byte is loaded only at a byte boundary fall edge
            if (fall)
            begin
                if (s_reg.cnt == 3'h0)
                    s_next.tx_sh = i_tx_byte;
                else
                    s_next.tx_sh = {s_reg.tx_sh[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            s_reg <= '0;
        else if (i_clk_en)
            s_reg <= s_next;
    end

    a_bit_count_wrap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && !i_cs_n && rise && s_reg.cnt == 3'h7) |=> (s_reg.cnt == 3'h0))
        else $error("bit counter did not wrap after eighth bit");

endmodule

// *** core/rsb_lqi_calc.sv ***
`timescale 1ns/1ps
module rsb_lqi_calc #(
    parameter int SYMBOLS = rsb_pkg::RSB_LQI_SYMBOLS,
    parameter int QWIDTH = rsb_pkg::RSB_LQI_QWIDTH
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Symbol stream
    input wire logic i_sync_found,
    input wire logic i_sym_valid,
    input wire logic [QWIDTH-1:0] i_sym_quality,
    // Result
    output logic o_done,
    output logic [QWIDTH-1:0] o_value
);
    import rsb_pkg::*;

    localparam int CW = $clog2(SYMBOLS + 1);
    localparam int SW = QWIDTH + $clog2(SYMBOLS);
    localparam logic [CW-1:0] LAST = CW'(SYMBOLS - 1);

    typedef struct packed {
        logic active;
        logic [CW-1:0] cnt;
        logic [SW-1:0] sum;
        logic done;
        logic [QWIDTH-1:0] value;
    } rsb_lqi_state_t;

    rsb_lqi_state_t s_reg;
    rsb_lqi_state_t s_next;
    logic [SW-1:0] sum_add;

    assign sum_add = s_reg.sum + SW'(i_sym_quality);
    assign o_done = s_reg.done;
    assign o_value = s_reg.value;

    always_comb
    begin
        s_next = s_reg;
        s_next.done = 1'b0;
        // A new sync word restarts the window
        if (i_sync_found)
        begin
            s_next.active = 1'b1;
            s_next.cnt = '0;
            s_next.sum = '0;
        end
        else if (s_reg.active && i_sym_valid)
        begin
            s_next.sum = sum_add;
            s_next.cnt = s_reg.cnt + CW'(1);
            if (s_reg.cnt == LAST)
            begin
                // Mean over the window, a power of two
                s_next.active = 1'b0;
                s_next.done = 1'b1;
                s_next.value = sum_add[SW-1 -: QWIDTH];
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
            s_reg <= '0;
        else if (i_clk_en)
            s_reg <= s_next;
    end

    a_lqi_window_len: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_clk_en && s_next.done) |-> (s_reg.cnt == LAST && s_reg.active))
        else $error("link quality finished before window filled");

endmodule

// *** core/rsb_status_bank.sv ***
`timescale 1ns/1ps
// Operation
// - Part number readable at status address 0x30
// - Chip revision readable at status address 0x31
// - Carrier offset reported as signed byte
// - Offset reads zero under amplitude keying
// - CRC match flag, cleared on receive entry
// - Link quality over 64 post-sync symbols
// - Signal strength readable at address 0x34
// - Radio state in low five bits
// - State field uses documented radio codes
// - Chip select wakes sleep or crystal-off
module rsb_status_bank #(
    parameter logic [7:0] PART_ID = rsb_pkg::RSB_PART_ID_DEF,
    parameter logic [7:0] REV_ID = rsb_pkg::RSB_REV_ID_DEF
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // Serial configuration port
    input wire rsb_pkg::rsb_spi_in_t i_spi,
    output logic o_so,
    output logic o_so_oe,
    // Radio status sources
    input wire rsb_pkg::rsb_radio_in_t i_radio,
    input wire rsb_pkg::rsb_sym_in_t i_sym,
    // Radio control
    output logic o_wake_req
);
    import rsb_pkg::*;

    rsb_bank_state_t s_reg;
    rsb_bank_state_t s_next;
    logic byte_done;
    logic [7:0] rx_byte;
    logic lqi_done;
    logic [6:0] lqi_value;
    logic hdr_is_status;
    logic hdr_in_range;
    logic [5:0] hdr_addr;
    logic sleepy;
    logic cs_fall;

    rsb_spi_shifter u_shifter (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_cs_n(i_spi.chip_select_low_n),
        .i_sclk(i_spi.sclk),
        .i_si(i_spi.si),
        .o_so(o_so),
        .o_so_oe(o_so_oe),
        .i_tx_byte(s_reg.tx_byte),
        .o_byte_done(byte_done),
        .o_rx_byte(rx_byte)
    );

    rsb_lqi_calc #(
        .SYMBOLS(RSB_LQI_SYMBOLS),
        .QWIDTH(RSB_LQI_QWIDTH)
    ) u_lqi (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_sync_found(i_sym.sync_found),
        .i_sym_valid(i_sym.sym_valid),
        .i_sym_quality(i_sym.sym_quality),
        .o_done(lqi_done),
        .o_value(lqi_value)
    );

    // Read mux; values are snapshotted into tx_byte so a byte never tears
    function automatic logic [7:0] read_mux(input rsb_bank_state_t st, input logic [5:0] a,
                                            input logic ask);
        logic [7:0] v;
        v = RSB_RST_BYTE;
        unique case (a)
            RSB_ADDR_PART: v = PART_ID;
            RSB_ADDR_REV: v = REV_ID;
            RSB_ADDR_OFFSET: v = ask ? RSB_RST_BYTE : st.offset_est;
            RSB_ADDR_LINK: v = {st.crc_ok, st.lqi};
            RSB_ADDR_SIGNAL_STRENGTH_LEVEL: v = st.signal_strength_level;
            RSB_ADDR_FSM: v = {RSB_FSM_PAD, st.radio_st};
            default: v = RSB_RST_BYTE;
        endcase
        return v;
    endfunction

    assign hdr_addr = rx_byte[RSB_HDR_ADDR_MSB:0];
    assign hdr_is_status = rx_byte[RSB_HDR_READ_BIT] && rx_byte[RSB_HDR_BURST_BIT];
    assign hdr_in_range = (hdr_addr >= RSB_ADDR_PART) && (hdr_addr <= RSB_ADDR_FSM);
    assign sleepy = (s_reg.radio_st == RSB_ST_SLEEP) || (s_reg.radio_st == RSB_ST_CRYSTAL_OFF_STATE);
    assign cs_fall = s_reg.cs_q && !i_spi.chip_select_low_n;
    assign o_wake_req = s_reg.wake;

    always_comb
    begin
        s_next = s_reg;
        s_next.wake = 1'b0;
        s_next.cs_q = i_spi.chip_select_low_n;

        // Only frequency keyed modes produce a meaningful estimate
        if (i_radio.offset_valid)
            s_next.offset_est = i_radio.mod_is_ask ? RSB_RST_BYTE : i_radio.freq_offset;

        // Receive entry clears, a comparison result in the same cycle wins
        if (i_radio.rx_enter)
            s_next.crc_ok = 1'b0;
        if (i_radio.crc_done)
            s_next.crc_ok = i_radio.crc_match;

        if (lqi_done)
            s_next.lqi = lqi_value;

        s_next.signal_strength_level = i_radio.signal_strength_level;
        s_next.radio_st = i_radio.radio_state;

        // Selecting the chip pulls the radio out of its low power states
        if (cs_fall && sleepy)
            s_next.wake = 1'b1;

        if (i_spi.chip_select_low_n)
        begin
            s_next.phase = RSB_PH_HEADER;
            s_next.tx_byte = RSB_HDR_STATUS;
        end
        else if (byte_done)
        begin
            unique case (s_reg.phase)
                RSB_PH_HEADER:
                begin
                    // Writes and other addresses fall through without effect
                    if (hdr_is_status && hdr_in_range)
                    begin
                        s_next.phase = RSB_PH_DATA;
                        s_next.addr = hdr_addr;
                        s_next.tx_byte = read_mux(s_reg, hdr_addr, i_radio.mod_is_ask);
                    end
                    else
                    begin
                        s_next.phase = RSB_PH_IGNORE;
                        s_next.tx_byte = RSB_RST_BYTE;
                    end
                end
                RSB_PH_DATA:
                begin
                    // Status registers do not auto-increment; repeat the same one
                    s_next.tx_byte = read_mux(s_reg, s_reg.addr, i_radio.mod_is_ask);
                end
                RSB_PH_IGNORE:
                begin
                    s_next.tx_byte = RSB_RST_BYTE;
                end
                default:
                begin
                    s_next.phase = RSB_PH_IGNORE;
                    s_next.tx_byte = RSB_RST_BYTE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_n)
        begin
            s_reg <= '0;
            s_reg.phase <= RSB_PH_HEADER;
            s_reg.tx_byte <= RSB_HDR_STATUS;
            s_reg.cs_q <= 1'b1;
        end
        else if (i_clk_en)
            s_reg <= s_next;
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence hdr_status_read(logic [5:0] a);
        i_clk_en && byte_done && s_reg.phase == RSB_PH_HEADER && hdr_is_status && hdr_addr == a;
    endsequence

    sequence hdr_write;
        i_clk_en && byte_done && s_reg.phase == RSB_PH_HEADER && !rx_byte[RSB_HDR_READ_BIT];
    endsequence

    sequence hdr_refused;
        i_clk_en && byte_done && s_reg.phase == RSB_PH_HEADER &&
        !(hdr_is_status && hdr_in_range);
    endsequence

    // Later bytes of a frame re-read the register named in the header
    sequence data_byte_at(logic [5:0] a);
        i_clk_en && byte_done && s_reg.phase == RSB_PH_DATA && s_reg.addr == a;
    endsequence

    a_part_id_read: assert property (hdr_status_read(RSB_ADDR_PART) |=>
        s_reg.tx_byte == PART_ID && s_reg.phase == RSB_PH_DATA)
        else $error("part number not loaded for read");

    a_rev_id_read: assert property (hdr_status_read(RSB_ADDR_REV) |=>
        s_reg.tx_byte == REV_ID)
        else $error("revision not loaded for read");

    a_offset_track: assert property ((i_clk_en && i_radio.offset_valid &&
        !i_radio.mod_is_ask) |=> s_reg.offset_est == $past(i_radio.freq_offset))
        else $error("offset estimate not captured");

    a_offset_ask_zero: assert property ((hdr_status_read(RSB_ADDR_OFFSET)
        and i_radio.mod_is_ask) |=> s_reg.tx_byte == RSB_RST_BYTE)
        else $error("offset nonzero under amplitude keying");

    a_crc_clear_rx: assert property ((i_clk_en && i_radio.rx_enter &&
        !i_radio.crc_done) |=> !s_reg.crc_ok)
        else $error("crc flag survived receive entry");

    a_crc_set_wins: assert property ((i_clk_en && i_radio.crc_done &&
        i_radio.crc_match) |=> s_reg.crc_ok)
        else $error("crc match lost");

    a_lqi_latch: assert property ((i_clk_en && lqi_done) |=>
        s_reg.lqi == $past(lqi_value))
        else $error("link quality not latched");

    a_signal_strength_level_read: assert property (hdr_status_read(RSB_ADDR_SIGNAL_STRENGTH_LEVEL) |=>
        s_reg.tx_byte == $past(s_reg.signal_strength_level))
        else $error("signal strength read mismatch");

    a_fsm_pad_zero: assert property (hdr_status_read(RSB_ADDR_FSM) |=>
        s_reg.tx_byte[7:5] == RSB_FSM_PAD && s_reg.tx_byte[4:0] == $past(s_reg.radio_st))
        else $error("state byte upper bits not zero");

    // Release edge excluded, the bank was still held in reset there
    a_state_track: assert property ((i_clk_en && i_rst_n) |=>
        s_reg.radio_st == $past(i_radio.radio_state))
        else $error("radio state not tracked");

    a_wake_on_select: assert property ((i_clk_en && cs_fall && sleepy) |=>
        o_wake_req)
        else $error("wake request not raised on select");

    a_write_ignored: assert property (hdr_write |=>
        s_reg.phase == RSB_PH_IGNORE && s_reg.tx_byte == RSB_RST_BYTE)
        else $error("write access was not ignored");

    a_idle_header: assert property ((i_clk_en && i_spi.chip_select_low_n) |=>
        s_reg.phase == RSB_PH_HEADER && s_reg.tx_byte == RSB_HDR_STATUS)
        else $error("idle bank not back in header phase");

    a_refused_zero: assert property (hdr_refused |=>
        s_reg.phase == RSB_PH_IGNORE && s_reg.tx_byte == RSB_RST_BYTE)
        else $error("refused header did not shift zero");

    a_ignore_stays: assert property ((i_clk_en && byte_done &&
        s_reg.phase == RSB_PH_IGNORE) |=>
        s_reg.phase == RSB_PH_IGNORE && s_reg.tx_byte == RSB_RST_BYTE)
        else $error("ignored frame left its zero phase");

    a_offset_read: assert property ((hdr_status_read(RSB_ADDR_OFFSET)
        and !i_radio.mod_is_ask) |=> s_reg.tx_byte == $past(s_reg.offset_est))
        else $error("offset estimate read mismatch");

    a_offset_ask_cap: assert property ((i_clk_en && i_radio.offset_valid &&
        i_radio.mod_is_ask) |=> s_reg.offset_est == RSB_RST_BYTE)
        else $error("offset captured under amplitude keying");

    a_offset_hold: assert property ((i_clk_en && !i_radio.offset_valid) |=>
        $stable(s_reg.offset_est))
        else $error("offset estimate changed without strobe");

    a_crc_hold: assert property ((i_clk_en && !i_radio.rx_enter &&
        !i_radio.crc_done) |=> $stable(s_reg.crc_ok))
        else $error("crc flag changed without event");

    a_link_read: assert property (hdr_status_read(RSB_ADDR_LINK) |=>
        s_reg.tx_byte == {$past(s_reg.crc_ok), $past(s_reg.lqi)})
        else $error("link quality read mismatch");

    a_signal_strength_level_track: assert property ((i_clk_en && i_rst_n) |=>
        s_reg.signal_strength_level == $past(i_radio.signal_strength_level))
        else $error("signal strength not tracked");

    // Bursts must not drift to a neighbouring register
    a_part_repeat: assert property (data_byte_at(RSB_ADDR_PART) |=>
        s_reg.tx_byte == PART_ID)
        else $error("part number lost in burst");

    a_rev_repeat: assert property (data_byte_at(RSB_ADDR_REV) |=>
        s_reg.tx_byte == REV_ID)
        else $error("revision lost in burst");

    a_fsm_repeat: assert property (data_byte_at(RSB_ADDR_FSM) |=>
        s_reg.tx_byte[7:5] == RSB_FSM_PAD)
        else $error("state byte upper bits set in burst");

    a_wake_only_select: assert property ((i_clk_en && !(cs_fall && sleepy)) |=>
        !o_wake_req)
        else $error("wake request without select");

    // A frozen bank must hold its state; status events in frozen cycles are dropped
    a_clk_en_freeze: assert property (!i_clk_en |=> $stable(s_reg))
        else $error("state moved while clock enable low");

endmodule

// *** dv/rsb_host_model.sv ***
`timescale 1ns/1ps
module rsb_host_model (
    // Clock
    input wire logic i_ref_clk,
    // Serial pins
    input wire logic i_so,
    output rsb_pkg::rsb_spi_in_t o_spi
);
    import rsb_pkg::*;

    initial
    begin
        o_spi = '{chip_select_low_n: 1'b1, sclk: 1'b0, si: 1'b1};
    end

    // Four clocks per half period, twice the minimum, so slow edges are exercised
    task automatic half();
        repeat (4) @(posedge i_ref_clk);
    endtask

    // Header byte then one data byte, mode 0, MSB first
    task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {hdr, wd};
        rd = 8'h00;
        @(posedge i_ref_clk);
        o_spi.chip_select_low_n <= 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge i_ref_clk);
            o_spi.sclk <= 1'b0;
            o_spi.si <= sh[i];
            half();
            if (i < 8)
                rd = {rd[6:0], i_so};
            o_spi.sclk <= 1'b1;
            half();
        end
        @(posedge i_ref_clk);
        o_spi.sclk <= 1'b0;
        o_spi.chip_select_low_n <= 1'b1;
        // Released line shows no stale level
        o_spi.si <= ~o_spi.si;
        half();
    endtask
endmodule

// *** dv/rsb_status_bank_tb.sv ***
`timescale 1ns/1ps
module rsb_status_bank_tb;
    import rsb_pkg::*;

    // Identity values, arbitrary
    localparam logic [7:0] PART = 8'h9E;
    localparam logic [7:0] REV = 8'h27;

    logic clk;
    logic rst_n;
    rsb_radio_in_t radio;
    rsb_sym_in_t sym;
    rsb_spi_in_t spi;
    logic so;
    logic so_oe;
    logic wake;
    logic ce;
    int failures = 0;
    int total_checks = 0;
    int wakes = 0;
    int oe_bad = 0;

    rsb_status_bank #(.PART_ID(PART), .REV_ID(REV)) uut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(ce), .i_spi(spi),
        .o_so(so), .o_so_oe(so_oe), .i_radio(radio), .i_sym(sym), .o_wake_req(wake));

    rsb_host_model host (.i_ref_clk(clk), .i_so(so), .o_spi(spi));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
        if (wake === 1'b1)
            wakes <= wakes + 1;

    // Pin driver enable must follow chip select in every cycle
    always @(posedge clk)
        if (so_oe !== !spi.chip_select_low_n && oe_bad < 255)
            oe_bad <= oe_bad + 1;

    task automatic complete_run();
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd_reg(input logic [7:0] hdr, input logic [7:0] exp);
        logic [7:0] d;
        host.xfer(hdr, 8'h00, d);
        chk8(d, exp);
    endtask

    task automatic t_ids();
        rd_reg(8'hF0, PART);
        rd_reg(8'hF1, REV);
    endtask

    // Zero under amplitude keying both for a held and a fresh estimate
    task automatic t_offset();
        radio.freq_offset <= 8'hC3;
        radio.offset_valid <= 1'b1;
        tick(1);
        radio.offset_valid <= 1'b0;
        tick(3);
        rd_reg(8'hF2, 8'hC3);
        radio.mod_is_ask <= 1'b1;
        tick(2);
        rd_reg(8'hF2, 8'h00);
        radio.freq_offset <= 8'h7F;
        radio.offset_valid <= 1'b1;
        tick(1);
        radio.offset_valid <= 1'b0;
        radio.mod_is_ask <= 1'b0;
        tick(3);
        rd_reg(8'hF2, 8'h00);
    endtask

    // Set wins when set and clear land together
    task automatic t_crc();
        radio.crc_match <= 1'b1;
        radio.crc_done <= 1'b1;
        tick(1);
        radio.crc_done <= 1'b0;
        tick(3);
        rd_reg(8'hF3, 8'h80);
        radio.rx_enter <= 1'b1;
        tick(1);
        radio.rx_enter <= 1'b0;
        tick(3);
        rd_reg(8'hF3, 8'h00);
        radio.rx_enter <= 1'b1;
        radio.crc_done <= 1'b1;
        tick(1);
        radio.rx_enter <= 1'b0;
        radio.crc_done <= 1'b0;
        radio.crc_match <= 1'b0;
        tick(3);
        rd_reg(8'hF3, 8'h80);
        radio.crc_done <= 1'b1;
        tick(1);
        radio.crc_done <= 1'b0;
        tick(3);
    endtask

    // Alternating qualities average to 0x40 over the window
    task automatic t_lqi();
        sym.sync_found <= 1'b1;
        tick(1);
        sym.sync_found <= 1'b0;
        for (int i = 0; i < 64; i++)
        begin
            sym.sym_valid <= 1'b1;
            sym.sym_quality <= (i % 2) ? 7'h31 : 7'h50;
            tick(1);
            sym.sym_valid <= 1'b0;
            tick(1);
        end
        tick(4);
        rd_reg(8'hF3, 8'h40);
    endtask

    task automatic t_signal_strength_level_write();
        logic [7:0] d;
        radio.signal_strength_level <= 8'hA7;
        tick(2);
        rd_reg(8'hF4, 8'hA7);
        host.xfer(8'h34, 8'hFF, d);
        host.xfer(8'h70, 8'h00, d);
        rd_reg(8'hF4, 8'hA7);
        rd_reg(8'hF0, PART);
        rd_reg(8'hF6, 8'h00);
        rd_reg(8'hB4, 8'h00);
    endtask

    // Codes 0x00 to 0x16 plus unlisted 0x1F; only sleep and crystal-off ask for wake
    task automatic t_state();
        logic [4:0] code;
        int w0;
        for (int c = 0; c < 24; c++)
        begin
            code = (c == 23) ? 5'h1F : 5'(c);
            radio.radio_state <= code;
            tick(2);
            w0 = wakes;
            rd_reg(8'hF5, {3'h0, code});
            chk8(8'(wakes - w0), (code == 5'h00 || code == 5'h02) ? 8'h01 : 8'h00);
        end
    endtask

    // Frozen cycles must drop status events
    task automatic t_freeze();
        ce <= 1'b0;
        radio.crc_match <= 1'b1;
        radio.crc_done <= 1'b1;
        sym.sync_found <= 1'b1;
        tick(2);
        radio.crc_done <= 1'b0;
        sym.sync_found <= 1'b0;
        ce <= 1'b1;
        tick(2);
        rd_reg(8'hF3, 8'h40);
        radio.crc_match <= 1'b0;
    endtask

    // Mid-run reset clears the captured CRC flag and link quality
    task automatic t_reset();
        radio.crc_match <= 1'b1;
        radio.crc_done <= 1'b1;
        tick(1);
        radio.crc_done <= 1'b0;
        tick(1);
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        tick(2);
        rd_reg(8'hF3, 8'h00);
    endtask

    initial
    begin
        rst_n = 1'b0;
        ce = 1'b1;
        radio = '0;
        sym = '0;
        tick(16);
        rst_n <= 1'b1;
        tick(2);
        t_ids();
        t_offset();
        t_crc();
        t_lqi();
        t_freeze();
        t_signal_strength_level_write();
        t_state();
        t_reset();
        chk8(8'(oe_bad), 8'h00);
        complete_run();
    end

    initial
    begin
        repeat (60000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule
